// ### shared/fpeg_pkg.sv
// Constants and types for the flash program/erase guard.
// Assumes a single 200 MHz clock and a plain strobe register port.
package fpeg_pkg;

	// ----------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------
	localparam logic [23:0] ADDR_PROG_SEL = 24'hfffde9;
	localparam logic [23:0] ADDR_ERASE_SEL = 24'hfffdea;
	localparam logic [23:0] ADDR_CTRL_STAT = 24'hfffdeb;
	localparam logic [23:0] ADDR_UNLOCK_KEY = 24'hfffdec;
	localparam logic [23:0] ADDR_BLOCK_NUM = 24'hfffdf0;
	localparam logic [23:0] ADDR_DEST_ADDR = 24'hfffdf4;
	localparam logic [23:0] ADDR_SRC_ADDR = 24'hfffdf8;
	localparam logic [23:0] ADDR_OP_CMD = 24'hfffdfc;
	localparam logic [23:0] ADDR_RESULT = 24'hfffdfd;

	// ----------------------------------------
	// Keys, reset values, field positions
	// ----------------------------------------
	localparam logic [7:0] KEY_COPY = 8'ha5;
	localparam logic [7:0] KEY_PROGRAM = 8'h5a;
	localparam logic [7:0] KEY_RESET = 8'h00;
	localparam int CHOOSE_BIT = 0;
	localparam int CTRL_COPY_BIT = 0;
	localparam int CTRL_ERRSTAT_BIT = 4;
	localparam int CMD_ERASE_BIT = 0;
	localparam int CMD_PROGRAM_BIT = 1;
	localparam logic [7:0] LAST_BLOCK = 8'h13;

	// ----------------------------------------
	// Flash and program geometry
	// ----------------------------------------
	localparam logic [31:0] FLASH_BASE = 32'h00000000;
	localparam logic [31:0] FLASH_LIMIT = 32'h00180000;
	localparam logic [7:0] ALIGN_LOW_A = 8'h00;
	localparam logic [7:0] ALIGN_LOW_B = 8'h80;
	localparam int PAGE_BYTES = 128;
	localparam logic [7:0] PAGE_LAST = 8'h7f;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_MHZ = 200;
	localparam int COPY_NS = 100;
	localparam int COPY_CYCLES = (COPY_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] COPY_CYCLES_W = 8'(COPY_CYCLES);

	// Result flags, one bit per cause
	typedef struct packed {
		logic spare7;
		logic protection_state_flag;
		logic execution_fail_flag;
		logic key_check_error_flag;
		logic block_number_error_flag;
		logic source_addr_error_flag;
		logic dest_addr_error_flag;
		logic overall_outcome_flag;
	} fpeg_result_type;

	// Port toward the flash array
	typedef struct packed {
		logic erase_start;
		logic program_start;
		logic [7:0] block;
		logic [31:0] dest;
		logic [31:0] src;
	} fpeg_flash_req_type;

	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_COPY = 4'b0010,
		ST_BUSY = 4'b0100,
		ST_DONE = 4'b1000
	} fpeg_state_type;

endpackage

// ### core/fpeg_guard.sv
// Flash program/erase guard: key gate, routine copy and parameter check.
// Assumes a CPU on a strobe port and a flash array answering done/fail.
//
// Design decision made here: the plain strobed port.
`timescale 1ns/100ps
module fpeg_guard (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [23:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic flash_error_status,
	input wire logic flash_done,
	input wire logic flash_fail,
	output fpeg_pkg::fpeg_flash_req_type flash_req,
	output logic copy_active,
	output logic copy_program,
	output logic copy_erase
);

	// ----------------------------------------
	// Synchroniser for the flash error status
	// ----------------------------------------
	logic [2:0] err_sync_reg;
	logic err_state_reg;

	// Three stages; level accepted once stages two and three agree
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			err_sync_reg <= 3'h0;
			err_state_reg <= 1'b0;
		end else begin
			err_sync_reg <= {err_sync_reg[1:0], flash_error_status};
			if (err_sync_reg[1] == err_sync_reg[2]) begin
				err_state_reg <= err_sync_reg[2];
			end
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] unlock_key_reg;
	logic program_routine_choose_bit;
	logic erase_routine_choose_bit;
	logic routine_copy_request;
	logic [7:0] block_num_reg;
	logic [31:0] dest_addr_reg;
	logic [31:0] src_addr_reg;
	fpeg_pkg::fpeg_result_type result_reg;
	fpeg_pkg::fpeg_result_type result_next;
	fpeg_pkg::fpeg_state_type state_reg;
	logic [7:0] copy_cnt_reg;
	logic op_is_erase_reg;
	logic copy_done;
	logic wr_key, wr_psel, wr_esel, wr_ctrl, wr_cmd;
	logic start_erase, start_program, start_op;

	assign wr_key = reg_wr && reg_addr == fpeg_pkg::ADDR_UNLOCK_KEY;
	assign wr_psel = reg_wr && reg_addr == fpeg_pkg::ADDR_PROG_SEL;
	assign wr_esel = reg_wr && reg_addr == fpeg_pkg::ADDR_ERASE_SEL;
	assign wr_ctrl = reg_wr && reg_addr == fpeg_pkg::ADDR_CTRL_STAT;
	assign wr_cmd = reg_wr && reg_addr == fpeg_pkg::ADDR_OP_CMD && state_reg == fpeg_pkg::ST_IDLE;
	assign start_erase = wr_cmd && reg_wdata[fpeg_pkg::CMD_ERASE_BIT];
	assign start_program = wr_cmd && !reg_wdata[fpeg_pkg::CMD_ERASE_BIT]
		&& reg_wdata[fpeg_pkg::CMD_PROGRAM_BIT];
	assign start_op = start_erase || start_program;
	assign copy_done = state_reg == fpeg_pkg::ST_COPY && copy_cnt_reg == 8'h01;

	// Unlock key
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			unlock_key_reg <= fpeg_pkg::KEY_RESET;
		end else if (wr_key) begin
			unlock_key_reg <= reg_wdata[7:0];
		end
	end

	// Routine choose bits; completion of the copy clears them
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			program_routine_choose_bit <= 1'b0;
			erase_routine_choose_bit <= 1'b0;
		end else begin
			if (copy_done) begin
				program_routine_choose_bit <= 1'b0;
				erase_routine_choose_bit <= 1'b0;
			end else begin
				if (wr_psel) begin
					program_routine_choose_bit <= reg_wdata[fpeg_pkg::CHOOSE_BIT];
				end
				if (wr_esel) begin
					erase_routine_choose_bit <= reg_wdata[fpeg_pkg::CHOOSE_BIT];
				end
			end
		end
	end

	// Copy request, taken only under the copy key
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			routine_copy_request <= 1'b0;
		end else if (copy_done) begin
			routine_copy_request <= 1'b0;
		end else if (wr_ctrl && reg_wdata[fpeg_pkg::CTRL_COPY_BIT]
			&& unlock_key_reg == fpeg_pkg::KEY_COPY && state_reg == fpeg_pkg::ST_IDLE) begin
			routine_copy_request <= 1'b1;
		end
	end

	// Operation parameters
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			block_num_reg <= 8'h00;
			dest_addr_reg <= 32'h00000000;
			src_addr_reg <= 32'h00000000;
		end else if (reg_wr) begin
			if (reg_addr == fpeg_pkg::ADDR_BLOCK_NUM) begin
				block_num_reg <= reg_wdata[7:0];
			end
			if (reg_addr == fpeg_pkg::ADDR_DEST_ADDR) begin
				dest_addr_reg <= reg_wdata;
			end
			if (reg_addr == fpeg_pkg::ADDR_SRC_ADDR) begin
				src_addr_reg <= reg_wdata;
			end
		end
	end

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	logic fault_any;
	logic dest_bad, src_bad, block_bad, key_bad;

	// Parameter checks made at the start of an operation
	always_comb begin
		key_bad = unlock_key_reg != fpeg_pkg::KEY_PROGRAM;
		block_bad = block_num_reg > fpeg_pkg::LAST_BLOCK;
		dest_bad = dest_addr_reg < fpeg_pkg::FLASH_BASE || dest_addr_reg >= fpeg_pkg::FLASH_LIMIT
			|| (dest_addr_reg[7:0] != fpeg_pkg::ALIGN_LOW_A
			&& dest_addr_reg[7:0] != fpeg_pkg::ALIGN_LOW_B);
		src_bad = src_addr_reg >= fpeg_pkg::FLASH_BASE && src_addr_reg < fpeg_pkg::FLASH_LIMIT;
		result_next = '0;
		result_next.protection_state_flag = err_state_reg;
		result_next.key_check_error_flag = key_bad;
		if (start_erase) begin
			result_next.block_number_error_flag = block_bad;
		end else begin
			result_next.source_addr_error_flag = src_bad;
			result_next.dest_addr_error_flag = dest_bad;
		end
		fault_any = result_next.protection_state_flag || result_next.key_check_error_flag
			|| result_next.block_number_error_flag || result_next.source_addr_error_flag
			|| result_next.dest_addr_error_flag;
	end

	// State machine: copy, then run or refuse operations
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			state_reg <= fpeg_pkg::ST_IDLE;
			copy_cnt_reg <= 8'h00;
			op_is_erase_reg <= 1'b0;
		end else begin
			case (state_reg)
				fpeg_pkg::ST_IDLE: begin
					if (wr_ctrl && reg_wdata[fpeg_pkg::CTRL_COPY_BIT]
						&& unlock_key_reg == fpeg_pkg::KEY_COPY) begin
						state_reg <= fpeg_pkg::ST_COPY;
						copy_cnt_reg <= fpeg_pkg::COPY_CYCLES_W;
					end else if (start_op) begin
						op_is_erase_reg <= start_erase;
						// Faults or protection skip the flash entirely
						state_reg <= fault_any ? fpeg_pkg::ST_DONE : fpeg_pkg::ST_BUSY;
					end
				end
				fpeg_pkg::ST_COPY: begin
					copy_cnt_reg <= copy_cnt_reg - 8'h01;
					if (copy_done) begin
						state_reg <= fpeg_pkg::ST_IDLE;
					end
				end
				fpeg_pkg::ST_BUSY: begin
					if (flash_done) begin
						state_reg <= fpeg_pkg::ST_DONE;
					end
				end
				fpeg_pkg::ST_DONE: begin
					state_reg <= fpeg_pkg::ST_IDLE;
				end
				default: begin
					state_reg <= fpeg_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Staged check result, published as a whole at the end
	fpeg_pkg::fpeg_result_type pend_reg;
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pend_reg <= '0;
			result_reg <= '0;
		end else begin
			if (state_reg == fpeg_pkg::ST_IDLE && start_op) begin
				pend_reg <= result_next;
				pend_reg.overall_outcome_flag <= fault_any;
			end else if (state_reg == fpeg_pkg::ST_BUSY && flash_done) begin
				pend_reg.execution_fail_flag <= flash_fail;
				pend_reg.overall_outcome_flag <= flash_fail;
			end
			if (state_reg == fpeg_pkg::ST_DONE) begin
				result_reg <= pend_reg;
			end
		end
	end

	// ----------------------------------------
	// Flash request and copy outputs
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			flash_req <= '0;
			copy_active <= 1'b0;
			copy_program <= 1'b0;
			copy_erase <= 1'b0;
		end else begin
			flash_req.erase_start <= start_erase && !fault_any;
			flash_req.program_start <= start_program && !fault_any;
			flash_req.block <= block_num_reg;
			flash_req.dest <= {dest_addr_reg[31:7], 7'h00};
			flash_req.src <= src_addr_reg;
			copy_active <= routine_copy_request && !copy_done;
			copy_program <= program_routine_choose_bit;
			copy_erase <= erase_routine_choose_bit;
		end
	end

	// ----------------------------------------
	// Read port, data one cycle after the strobe
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			reg_rdata <= 32'h00000000;
		end else if (reg_rd) begin
			case (reg_addr)
				fpeg_pkg::ADDR_PROG_SEL: reg_rdata <= {31'h0, program_routine_choose_bit};
				fpeg_pkg::ADDR_ERASE_SEL: reg_rdata <= {31'h0, erase_routine_choose_bit};
				fpeg_pkg::ADDR_CTRL_STAT: reg_rdata <= {27'h0, err_state_reg, 4'h0};
				fpeg_pkg::ADDR_UNLOCK_KEY: reg_rdata <= {24'h0, unlock_key_reg};
				fpeg_pkg::ADDR_BLOCK_NUM: reg_rdata <= {24'h0, block_num_reg};
				fpeg_pkg::ADDR_DEST_ADDR: reg_rdata <= dest_addr_reg;
				fpeg_pkg::ADDR_SRC_ADDR: reg_rdata <= src_addr_reg;
				fpeg_pkg::ADDR_OP_CMD: reg_rdata <= {28'h0, state_reg};
				fpeg_pkg::ADDR_RESULT: reg_rdata <= {24'h0, result_reg};
				default: reg_rdata <= 32'h00000000;
			endcase
		end else begin
			reg_rdata <= 32'h00000000;
		end
	end

endmodule

// ### bench/fpeg_flash_model.sv
// Behavioural flash array behind the guard.
// Assumes start pulses arrive on ref_clk.
`timescale 1ns/100ps
module fpeg_flash_model #(parameter int DLY = 6) (
	input wire logic ref_clk,
	input wire logic rst,
	input fpeg_pkg::fpeg_flash_req_type flash_req,
	input wire logic fail_mode,
	output logic flash_done,
	output logic flash_fail
);
	int cnt;
	// Answer each start once, DLY cycles later
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			cnt <= 0;
			flash_done <= 1'b0;
		end else if (flash_req.erase_start || flash_req.program_start) begin
			cnt <= DLY;
			flash_done <= 1'b0;
		end else begin
			cnt <= (cnt > 0) ? cnt - 1 : 0;
			flash_done <= (cnt == 1);
		end
	end
	// Fail flag only means something beside done
	always_ff @(posedge ref_clk) begin
		if (cnt == 1)
			flash_fail <= fail_mode;
		else
			flash_fail <= ~flash_fail;
	end
endmodule

// ### bench/fpeg_guard_props.sv
// Port checker for the program/erase guard.
// Assumes binding onto fpeg_guard, one clock.
`timescale 1ns/100ps
module fpeg_guard_props (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [23:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic flash_error_status,
	input wire logic flash_done,
	input wire logic flash_fail,
	input fpeg_pkg::fpeg_flash_req_type flash_req,
	input wire logic copy_active,
	input wire logic copy_program,
	input wire logic copy_erase
);
	logic [7:0] key_seen;
	logic [7:0] act_cnt;
	wire logic ctl_wr = reg_wr && reg_addr == fpeg_pkg::ADDR_CTRL_STAT && reg_wdata[0];
	wire logic any_start = flash_req.erase_start || flash_req.program_start;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	// Key shadow from register writes
	always_ff @(posedge ref_clk) begin
		if (rst)
			key_seen <= 8'h00;
		else if (reg_wr && reg_addr == fpeg_pkg::ADDR_UNLOCK_KEY)
			key_seen <= reg_wdata[7:0];
	end
	// Cycles spent copying
	always_ff @(posedge ref_clk) begin
		act_cnt <= (rst || !copy_active) ? 8'h00 : act_cnt + 8'h01;
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	chk_copy_take: assert property (ctl_wr && key_seen == fpeg_pkg::KEY_COPY && !copy_active |-> ##2 copy_active)
		else $error("copy not started");
	chk_copy_refuse: assert property (ctl_wr && key_seen != fpeg_pkg::KEY_COPY && !copy_active |-> ##2 !copy_active)
		else $error("copy started without key");
	// Active flag rises one cycle after the copy state but falls with it, so it stands one cycle short
	chk_copy_length: assert property ($fell(copy_active) |-> act_cnt == fpeg_pkg::COPY_CYCLES_W - 8'h01)
		else $error("copy length wrong");
	chk_choose_clear: assert property ($fell(copy_active) |-> ##[0:2] (!copy_program && !copy_erase))
		else $error("choose bit not cleared");
	chk_key_gate: assert property (any_start |-> key_seen == fpeg_pkg::KEY_PROGRAM)
		else $error("start without program key");
	chk_block_range: assert property (flash_req.erase_start |-> flash_req.block <= fpeg_pkg::LAST_BLOCK)
		else $error("erase of bad block");
	chk_src_outside: assert property (flash_req.program_start |-> flash_req.src >= fpeg_pkg::FLASH_LIMIT)
		else $error("source inside flash");
	chk_dest_shape: assert property (flash_req.program_start |-> flash_req.dest < fpeg_pkg::FLASH_LIMIT
		&& flash_req.dest[6:0] == 7'h00)
		else $error("bad destination");
	chk_protect_block: assert property (flash_error_status [*6] |-> !any_start)
		else $error("start under protection");
	cov_copy: cover property ($fell(copy_active));
	cov_erase: cover property (flash_req.erase_start);
	cov_program: cover property (flash_req.program_start);
endmodule
bind fpeg_guard fpeg_guard_props chk (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.flash_error_status(flash_error_status), .flash_done(flash_done), .flash_fail(flash_fail),
	.flash_req(flash_req), .copy_active(copy_active), .copy_program(copy_program), .copy_erase(copy_erase));

// ### bench/fpeg_guard_tb.sv
// Self-checking bench for the program/erase guard.
// Assumes the flash model and checker compile first.
`timescale 1ns/100ps
module fpeg_guard_tb;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [23:0] reg_addr = 24'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic flash_error_status = 1'b0;
	logic fail_mode = 1'b0;
	logic [31:0] reg_rdata;
	logic [31:0] rd_val;
	logic flash_done, flash_fail, copy_active, copy_program, copy_erase;
	fpeg_pkg::fpeg_flash_req_type flash_req;
	int miscompares = 0;
	int total_checks = 0;
	int starts = 0;
	fpeg_guard dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .flash_error_status(flash_error_status),
		.flash_done(flash_done), .flash_fail(flash_fail), .flash_req(flash_req),
		.copy_active(copy_active), .copy_program(copy_program), .copy_erase(copy_erase));
	fpeg_flash_model far (.ref_clk(ref_clk), .rst(rst), .flash_req(flash_req), .fail_mode(fail_mode),
		.flash_done(flash_done), .flash_fail(flash_fail));
	// ----------------------------------------
	// Clock, start counter, watchdog
	// ----------------------------------------
	initial forever #2.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		starts <= starts + ((flash_req.erase_start === 1'b1 || flash_req.program_start === 1'b1) ? 1 : 0);
	end
	initial begin
		#100000;
		miscompares++;
		end_of_test();
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic end_of_test();
		if (miscompares == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		total_checks++;
		if (seen !== want) begin
			miscompares++;
			$display("BAD %s expected %h seen %h", what, want, seen);
		end
	endtask
	task automatic wr(input logic [23:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [23:0] a);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 rd_val = reg_rdata;
	endtask
	// Run one command, wait for idle, judge flags and flash starts
	task automatic op(input string what, input logic [31:0] cmd, input logic [7:0] want);
		int n;
		int s0;
		n = 0;
		s0 = starts;
		wr(fpeg_pkg::ADDR_OP_CMD, cmd);
		repeat (3) @(posedge ref_clk);
		rd(fpeg_pkg::ADDR_OP_CMD);
		while (rd_val[3:0] !== fpeg_pkg::ST_IDLE && n < 50) begin
			rd(fpeg_pkg::ADDR_OP_CMD);
			n++;
		end
		check("op finished", rd_val, {28'h0, fpeg_pkg::ST_IDLE});
		rd(fpeg_pkg::ADDR_RESULT);
		check(what, rd_val, {24'h0, want});
		check("flash starts", starts - s0, (!want[0] || want[5]) ? 1 : 0);
	endtask
	// Copy refused with key cleared, then accepted with copy key
	task automatic copy_case(input logic [23:0] sel);
		int n;
		n = 0;
		wr(fpeg_pkg::ADDR_UNLOCK_KEY, 32'h0);
		wr(sel, 32'h1);
		rd(sel);
		check("select set", rd_val, 32'h1);
		wr(fpeg_pkg::ADDR_CTRL_STAT, 32'h1);
		repeat (4) @(posedge ref_clk);
		check("copy refused", copy_active, 32'h0);
		wr(fpeg_pkg::ADDR_UNLOCK_KEY, 32'ha5);
		wr(fpeg_pkg::ADDR_CTRL_STAT, 32'h1);
		@(posedge ref_clk);
		#1 check("copy running", copy_active, 32'h1);
		check("program chosen", copy_program, sel == fpeg_pkg::ADDR_PROG_SEL);
		check("erase chosen", copy_erase, sel == fpeg_pkg::ADDR_ERASE_SEL);
		while (copy_active === 1'b1 && n < 100) begin
			@(posedge ref_clk);
			n++;
		end
		check("copy ended", copy_active, 32'h0);
		rd(sel);
		check("select cleared", rd_val, 32'h0);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (3) @(posedge ref_clk);
		rst <= 1'b0;
		rd(fpeg_pkg::ADDR_UNLOCK_KEY);
		check("key reset", rd_val, 32'h0);
		wr(24'hfffd00, 32'h5a);
		rd(24'hfffd00);
		check("unmapped read", rd_val, 32'h0);
		rd(fpeg_pkg::ADDR_UNLOCK_KEY);
		check("key after stray write", rd_val, 32'h0);
		copy_case(fpeg_pkg::ADDR_PROG_SEL);
		copy_case(fpeg_pkg::ADDR_ERASE_SEL);
		wr(fpeg_pkg::ADDR_UNLOCK_KEY, 32'h5a);
		wr(fpeg_pkg::ADDR_BLOCK_NUM, 32'd19);
		op("erase block 19", 32'h1, 8'h00);
		check("erase block", flash_req.block, 32'd19);
		wr(fpeg_pkg::ADDR_BLOCK_NUM, 32'd20);
		op("erase block 20", 32'h1, 8'h09);
		wr(fpeg_pkg::ADDR_DEST_ADDR, 32'h00001080);
		wr(fpeg_pkg::ADDR_SRC_ADDR, 32'h00ff0000);
		op("program ok", 32'h2, 8'h00);
		check("program dest", flash_req.dest, 32'h00001080);
		check("program src", flash_req.src, 32'h00ff0000);
		wr(fpeg_pkg::ADDR_DEST_ADDR, 32'h00001081);
		op("dest low byte", 32'h2, 8'h03);
		check("dest forced", flash_req.dest, 32'h00001080);
		wr(fpeg_pkg::ADDR_DEST_ADDR, fpeg_pkg::FLASH_LIMIT);
		op("dest outside", 32'h2, 8'h03);
		wr(fpeg_pkg::ADDR_DEST_ADDR, 32'h00001000);
		wr(fpeg_pkg::ADDR_SRC_ADDR, 32'h00000100);
		op("source in flash", 32'h2, 8'h05);
		wr(fpeg_pkg::ADDR_BLOCK_NUM, 32'd0);
		wr(fpeg_pkg::ADDR_UNLOCK_KEY, 32'ha5);
		op("erase wrong key", 32'h1, 8'h11);
		wr(fpeg_pkg::ADDR_UNLOCK_KEY, 32'h5a);
		op("erase wins", 32'h3, 8'h00);
		fail_mode <= 1'b1;
		op("erase fails", 32'h1, 8'h21);
		fail_mode <= 1'b0;
		flash_error_status <= 1'b1;
		repeat (8) @(posedge ref_clk);
		rd(fpeg_pkg::ADDR_CTRL_STAT);
		check("error status", rd_val[4], 32'h1);
		op("erase protected", 32'h1, 8'h41);
		end_of_test();
	end
endmodule
